// ### rtl/can_stf_pkg.sv
package can_stf_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_ERROR_COUNT_STATE = 8'h00;
    localparam logic [7:0] OFF_FIFO_INTERRUPT_PENDING = 8'h04;
    localparam logic [7:0] OFF_RX_FIFO_OVERFLOW_PENDING = 8'h08;
    localparam logic [7:0] OFF_TIMESTAMP_TIMER = 8'h0c;
    localparam logic [7:0] OFF_FILTER_CONTROL_TWO = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_TX_BUS_OFF = 21;
    localparam int BIT_TX_PASSIVE = 20;
    localparam int BIT_RX_PASSIVE = 19;
    localparam int BIT_TX_WARNING = 18;
    localparam int BIT_RX_WARNING = 17;
    localparam int BIT_ANY_WARNING = 16;
    localparam int TX_CNT_LSB = 8;
    localparam int RX_CNT_LSB = 0;
    localparam int TS_COUNT_LSB = 16;
    localparam int TS_PRESCALE_LSB = 0;
    localparam int FILTER_NINE_LSB = 8;
    localparam int FILTER_EIGHT_LSB = 0;
    localparam int FLT_ENABLE_BIT = 7;
    localparam int FLT_MASK_LSB = 5;
    localparam int FLT_FIFO_LSB = 0;

    // ------------------------------------------------------------
    // Fault-confinement thresholds and steps
    // ------------------------------------------------------------
    localparam logic [8:0] TX_BUS_OFF_LEVEL = 9'h100;
    localparam logic [8:0] PASSIVE_LEVEL = 9'h080;
    localparam logic [8:0] WARNING_LEVEL = 9'h060;
    localparam logic [8:0] TX_ERROR_STEP = 9'h008;
    localparam logic [8:0] RX_PRIMARY_STEP = 9'h008;
    localparam logic [8:0] RX_ERROR_STEP = 9'h001;
    localparam logic [8:0] RX_RECOVER_VALUE = 9'h077;
    localparam logic [8:0] RX_CNT_MAX = 9'h0ff;
    localparam logic [7:0] CNT_DISPLAY_MAX = 8'hff;

    // ------------------------------------------------------------
    // Interrupt event bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 6;
    localparam int EV_TX_BUS_OFF = 0;
    localparam int EV_TX_PASSIVE = 1;
    localparam int EV_RX_PASSIVE = 2;
    localparam int EV_WARNING = 3;
    localparam int EV_OVERFLOW = 4;
    localparam int EV_TS_WRAP = 5;

    // Timer constants
    localparam logic [15:0] TS_ONE = 16'h0001;
    localparam logic [15:0] TS_MAX = 16'hffff;

endpackage

// ### rtl/ts_link_if.sv
// Carries the timestamp timer controls and state between the register
// block and the timer module.
interface ts_link_if;
    logic capture_enable;
    logic load;
    logic [31:0] load_value;
    logic [15:0] timestamp_count;
    logic [15:0] timestamp_prescale;
    logic wrap;

    modport ctrl (
        output capture_enable,
        output load,
        output load_value,
        input timestamp_count,
        input timestamp_prescale,
        input wrap
    );

    modport timer (
        input capture_enable,
        input load,
        input load_value,
        output timestamp_count,
        output timestamp_prescale,
        output wrap
    );
endinterface

// ### rtl/can_ts_timer.sv
module can_ts_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link to register block
    ts_link_if.timer link
);
    import can_stf_pkg::*;

    typedef struct packed {
        logic [15:0] pre_cnt;
        logic [15:0] count;
        logic [15:0] prescale;
    } ts_state_type;

    ts_state_type state;
    ts_state_type next_state;
    logic tick;

    // ------------------------------------------------------------
    // Prescaler period: zero behaves as one clock
    // ------------------------------------------------------------
    function automatic logic [15:0] last_pre(input logic [15:0] pre);
        last_pre = (pre == '0) ? '0 : pre - TS_ONE;
    endfunction

    // Next-state logic
    always_comb begin
        next_state = state;
        tick = 1'b0;
        if (link.load) begin
            // Software write restarts the prescaler, loads count and prescale setting
            next_state.pre_cnt = '0;
            next_state.count = link.load_value[TS_COUNT_LSB +: 16];
            next_state.prescale = link.load_value[TS_PRESCALE_LSB +: 16];
        end else if (link.capture_enable) begin
            if (state.pre_cnt >= last_pre(state.prescale)) begin
                tick = 1'b1;
                next_state.pre_cnt = '0;
                next_state.count = state.count + TS_ONE;
            end else begin
                next_state.pre_cnt = state.pre_cnt + TS_ONE;
            end
        end
        // Capture disabled: everything holds
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.timestamp_count = state.count;
    assign link.timestamp_prescale = state.prescale;
    assign link.wrap = tick && (state.count == TS_MAX); // Counter rolls over
endmodule

// ### rtl/can_status_timer_filter_ctrl.sv
// The address map and the plain strobed port were decided locally.
module can_status_timer_filter_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [can_stf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Protocol engine fault events
    input wire logic tx_error_event,
    input wire logic tx_success_event,
    input wire logic rx_error_event,
    input wire logic rx_primary_error_event,
    input wire logic rx_success_event,
    input wire logic bus_off_recovered,
    // FIFO state from message buffers
    input wire logic [31:0] fifo_irq_pending_in,
    input wire logic [31:0] rx_fifo_overflow_in,
    // Capture enable from the main control register
    input wire logic timestamp_capture_enable,
    // Fault-confinement state to the protocol engine
    output logic tx_bus_off_flag,
    output logic tx_error_passive_flag,
    output logic rx_error_passive_flag,
    output logic any_warning_flag,
    // Timestamp to the receive path
    output logic [15:0] timestamp_count,
    // Filter setup to the acceptance logic
    output logic filter_nine_enable,
    output logic [1:0] filter_nine_mask_select,
    output logic [4:0] filter_nine_fifo_select,
    output logic filter_eight_enable,
    output logic [1:0] filter_eight_mask_select,
    output logic [4:0] filter_eight_fifo_select,
    // Interrupt
    output logic irq
);
    import can_stf_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] tx_err;
        logic [8:0] rx_err;
        logic [31:0] fifo_ip;
        logic [31:0] rx_ovf;
        logic [7:0] filter_nine;
        logic [7:0] filter_eight;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic [3:0] prev_state;
        logic [31:0] rdata;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;

    ts_link_if ts_link ();

    logic tx_bo;
    logic tx_bp;
    logic rx_bp;
    logic tx_warn;
    logic rx_warn;
    logic warn_any;
    logic [31:0] error_word;
    logic [31:0] timer_word;
    logic [31:0] filter_word;
    logic [IRQ_W-1:0] events;
    logic [3:0] cur_state;
    logic wr_timer;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Saturating add, keeps a counter from wrapping back to zero
    function automatic logic [8:0] sat_add(input logic [8:0] val, input logic [8:0] step,
                                           input logic [8:0] limit);
        logic [9:0] sum;
        sum = {1'b0, val} + {1'b0, step};
        sat_add = (sum > {1'b0, limit}) ? limit : sum[8:0];
    endfunction

    // Decrement that stops at zero
    function automatic logic [8:0] sat_dec(input logic [8:0] val);
        sat_dec = (val == '0) ? '0 : val - 9'h001;
    endfunction

    // Warning band: at least the warning level, below passive
    function automatic logic in_warning(input logic [8:0] val);
        in_warning = (val >= WARNING_LEVEL) && (val < PASSIVE_LEVEL);
    endfunction

    // Counter view for software; bus-off count shows as full scale
    function automatic logic [7:0] count_view(input logic [8:0] val);
        count_view = val[8] ? CNT_DISPLAY_MAX : val[7:0];
    endfunction

    // Filter byte update: enable always writable, rest only while off
    function automatic logic [7:0] filter_write(input logic [7:0] cur, input logic [7:0] wr);
        logic [7:0] res;
        res = cur;
        res[FLT_ENABLE_BIT] = wr[FLT_ENABLE_BIT];
        if (!cur[FLT_ENABLE_BIT]) begin
            res[FLT_ENABLE_BIT-1:0] = wr[FLT_ENABLE_BIT-1:0];
        end
        filter_write = res;
    endfunction

    // ------------------------------------------------------------
    // Fault-confinement flags, decoded straight from the counters
    // ------------------------------------------------------------
    assign tx_bo = state.tx_err >= TX_BUS_OFF_LEVEL;
    assign tx_bp = state.tx_err >= PASSIVE_LEVEL;
    assign rx_bp = state.rx_err >= PASSIVE_LEVEL;
    assign tx_warn = in_warning(state.tx_err);
    assign rx_warn = in_warning(state.rx_err);
    assign warn_any = tx_warn || rx_warn;

    // Readable words
    always_comb begin
        error_word = '0;
        error_word[BIT_TX_BUS_OFF] = tx_bo;
        error_word[BIT_TX_PASSIVE] = tx_bp;
        error_word[BIT_RX_PASSIVE] = rx_bp;
        error_word[BIT_TX_WARNING] = tx_warn;
        error_word[BIT_RX_WARNING] = rx_warn;
        error_word[BIT_ANY_WARNING] = warn_any;
        error_word[TX_CNT_LSB +: 8] = count_view(state.tx_err);
        error_word[RX_CNT_LSB +: 8] = state.rx_err[7:0];
        timer_word = '0;
        timer_word[TS_COUNT_LSB +: 16] = ts_link.timestamp_count;
        timer_word[TS_PRESCALE_LSB +: 16] = ts_link.timestamp_prescale;
        filter_word = '0;
        filter_word[FILTER_NINE_LSB +: 8] = state.filter_nine;
        filter_word[FILTER_EIGHT_LSB +: 8] = state.filter_eight;
    end

    // ------------------------------------------------------------
    // Interrupt events: entry into bus-off, either passive state or any warning, new overflow,
    // timer wrap. Edge detection keeps a lingering state from
    // re-raising the flag right after software clears it.
    // ------------------------------------------------------------
    assign cur_state = {warn_any, rx_bp, tx_bp, tx_bo};

    always_comb begin
        events = '0;
        events[EV_TX_BUS_OFF] = tx_bo && !state.prev_state[0];
        events[EV_TX_PASSIVE] = tx_bp && !state.prev_state[1];
        events[EV_RX_PASSIVE] = rx_bp && !state.prev_state[2];
        events[EV_WARNING] = warn_any && !state.prev_state[3];
        events[EV_OVERFLOW] = |(rx_fifo_overflow_in & ~state.rx_ovf);
        events[EV_TS_WRAP] = ts_link.wrap;
    end

    // ------------------------------------------------------------
    // Timer link
    // ------------------------------------------------------------
    assign wr_timer = reg_write && (reg_addr == OFF_TIMESTAMP_TIMER);
    assign ts_link.capture_enable = timestamp_capture_enable;
    assign ts_link.load = wr_timer;
    assign ts_link.load_value = reg_wdata;

    can_ts_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .link(ts_link.timer)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Transmit counter; bus-off holds until recovery
        if (bus_off_recovered) begin
            next_state.tx_err = '0;
        end else if (!tx_bo) begin
            if (tx_error_event) begin
                next_state.tx_err = sat_add(state.tx_err, TX_ERROR_STEP, TX_BUS_OFF_LEVEL);
            end else if (tx_success_event) begin
                next_state.tx_err = sat_dec(state.tx_err);
            end
        end

        // Receive counter; success at or above passive drops into range
        if (bus_off_recovered) begin
            next_state.rx_err = '0;
        end else if (rx_primary_error_event) begin
            next_state.rx_err = sat_add(state.rx_err, RX_PRIMARY_STEP, RX_CNT_MAX);
        end else if (rx_error_event) begin
            next_state.rx_err = sat_add(state.rx_err, RX_ERROR_STEP, RX_CNT_MAX);
        end else if (rx_success_event) begin
            if (state.rx_err >= PASSIVE_LEVEL) begin
                next_state.rx_err = RX_RECOVER_VALUE;
            end else begin
                next_state.rx_err = sat_dec(state.rx_err);
            end
        end

        // FIFO summaries sampled every clock
        next_state.fifo_ip = fifo_irq_pending_in;
        next_state.rx_ovf = rx_fifo_overflow_in;
        next_state.prev_state = cur_state;

        // Register writes; read-only words ignore writes
        if (reg_write) begin
            case (reg_addr)
                OFF_FILTER_CONTROL_TWO: begin
                    next_state.filter_nine = filter_write(state.filter_nine,
                                                          reg_wdata[FILTER_NINE_LSB +: 8]);
                    next_state.filter_eight = filter_write(state.filter_eight,
                                                           reg_wdata[FILTER_EIGHT_LSB +: 8]);
                end
                OFF_IRQ_ENABLE: begin
                    next_state.irq_enable = reg_wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky status: write-one clears, a new event wins
        if (reg_write && (reg_addr == OFF_IRQ_CLEAR)) begin
            next_state.irq_status = (state.irq_status & ~reg_wdata[IRQ_W-1:0]) | events;
        end else begin
            next_state.irq_status = state.irq_status | events;
        end

        // Read data stand in the cycle after the strobe only
        next_state.rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                OFF_ERROR_COUNT_STATE: next_state.rdata = error_word;
                OFF_FIFO_INTERRUPT_PENDING: next_state.rdata = state.fifo_ip;
                OFF_RX_FIFO_OVERFLOW_PENDING: next_state.rdata = state.rx_ovf;
                OFF_TIMESTAMP_TIMER: next_state.rdata = timer_word;
                OFF_FILTER_CONTROL_TWO: next_state.rdata = filter_word;
                OFF_IRQ_STATUS: next_state.rdata = {{(32-IRQ_W){1'b0}}, state.irq_status};
                OFF_IRQ_ENABLE: next_state.rdata = {{(32-IRQ_W){1'b0}}, state.irq_enable};
                default: next_state.rdata = '0; // Unmapped and clear register read zero
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = state.rdata;
    assign tx_bus_off_flag = tx_bo;
    assign tx_error_passive_flag = tx_bp;
    assign rx_error_passive_flag = rx_bp;
    assign any_warning_flag = warn_any;
    assign timestamp_count = ts_link.timestamp_count;
    assign filter_nine_enable = state.filter_nine[FLT_ENABLE_BIT];
    assign filter_nine_mask_select = state.filter_nine[FLT_MASK_LSB +: 2];
    assign filter_nine_fifo_select = state.filter_nine[FLT_FIFO_LSB +: 5];
    assign filter_eight_enable = state.filter_eight[FLT_ENABLE_BIT];
    assign filter_eight_mask_select = state.filter_eight[FLT_MASK_LSB +: 2];
    assign filter_eight_fifo_select = state.filter_eight[FLT_FIFO_LSB +: 5];
    assign irq = |(state.irq_status & state.irq_enable); // Level while any enabled bit set
endmodule

// ### test/can_stf_props.sv
module can_stf_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [can_stf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Block inputs
    input wire logic [31:0] fifo_irq_pending_in,
    input wire logic timestamp_capture_enable,
    // Block outputs
    input wire logic any_warning_flag,
    input wire logic [15:0] timestamp_count,
    input wire logic filter_nine_enable,
    input wire logic [1:0] filter_nine_mask_select,
    input wire logic [4:0] filter_nine_fifo_select,
    input wire logic filter_eight_enable,
    input wire logic [1:0] filter_eight_mask_select,
    input wire logic [4:0] filter_eight_fifo_select
);
    timeunit 1ns;
    timeprecision 1ns;
    import can_stf_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Reads whose answer stands in the following cycle
    sequence s_err_read;
        reg_read && reg_addr == OFF_ERROR_COUNT_STATE;
    endsequence
    sequence s_fifo_read;
        reg_read && reg_addr == OFF_FIFO_INTERRUPT_PENDING;
    endsequence
    // Two quiet cycles, so a load by a write is not taken for a step
    sequence s_no_write2;
        !reg_write ##1 !reg_write;
    endsequence

    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside an answer");
    a_bus_off_word: assert property (s_err_read ##1 reg_rdata[21] |-> reg_rdata[20] && reg_rdata[15:8] == 8'hff)
        else $error("bus-off word inconsistent");
    a_tx_passive_bit: assert property (s_err_read |=> reg_rdata[20] == (reg_rdata[21] || reg_rdata[15]))
        else $error("tx passive bit wrong");
    a_rx_state_bits: assert property (s_err_read |=> reg_rdata[19] == reg_rdata[7] && reg_rdata[17] == (reg_rdata[7:5] == 3'b011))
        else $error("rx state bits wrong");
    a_tx_warn_range: assert property (s_err_read |=> reg_rdata[18] == (!reg_rdata[21] && reg_rdata[15:13] == 3'b011))
        else $error("tx warning bit wrong");
    a_any_warn_bit: assert property (s_err_read |=> reg_rdata[16] == (reg_rdata[18] || reg_rdata[17]) && reg_rdata[16] == $past(any_warning_flag))
        else $error("combined warning wrong");
    a_fifo_pending: assert property (s_fifo_read |=> reg_rdata == $past(fifo_irq_pending_in, 2))
        else $error("fifo pending word wrong");
    a_ts_frozen: assert property ((!timestamp_capture_enable && !reg_write) [*2] |=> $stable(timestamp_count))
        else $error("timer moved while disabled");
    a_ts_step_one: assert property (s_no_write2 ##1 timestamp_count != $past(timestamp_count) |-> timestamp_count == $past(timestamp_count) + 16'h1)
        else $error("timer stepped by other than one");
    a_nine_locked: assert property (filter_nine_enable ##1 filter_nine_enable |-> $stable({filter_nine_mask_select, filter_nine_fifo_select}))
        else $error("filter nine changed while enabled");
    a_eight_locked: assert property (filter_eight_enable ##1 filter_eight_enable |-> $stable({filter_eight_mask_select, filter_eight_fifo_select}))
        else $error("filter eight changed while enabled");
endmodule

// ### test/can_node_model.sv
module can_node_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Command from the bench
    input wire logic fire,
    input wire logic [2:0] kind,
    // Bus outcomes as the protocol engine reports them
    output logic [5:0] event_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // One outcome per frame, never two at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            event_pulse <= 6'h0;
        end else begin
            event_pulse <= fire ? 6'h1 << kind : 6'h0;
        end
    end
endmodule

// ### test/test_can_status_timer_filter_ctrl.sv
module test_can_status_timer_filter_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import can_stf_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata, fifo_pend = 32'h0, fifo_ovf = 32'h0;
    logic fire = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [5:0] ev;
    logic cap = 1'b0;
    logic bo, txp, rxp, anyw, irq, en9, en8;
    logic [15:0] ts;
    logic [1:0] m9, m8;
    logic [4:0] f9, f8;
    int num_errors = 0;
    int checked = 0;
    int seed = 21;
    int cycles = 0;
    int tx = 0;
    int rx = 0;

    can_node_model can_node_model_inst (.clk_sys(clk_sys), .rst(rst), .fire(fire), .kind(kind), .event_pulse(ev));
    can_status_timer_filter_ctrl can_status_timer_filter_ctrl_inst (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_error_event(ev[0]), .tx_success_event(ev[1]),
        .rx_error_event(ev[2]), .rx_primary_error_event(ev[3]), .rx_success_event(ev[4]),
        .bus_off_recovered(ev[5]), .fifo_irq_pending_in(fifo_pend), .rx_fifo_overflow_in(fifo_ovf),
        .timestamp_capture_enable(cap), .tx_bus_off_flag(bo), .tx_error_passive_flag(txp),
        .rx_error_passive_flag(rxp), .any_warning_flag(anyw), .timestamp_count(ts),
        .filter_nine_enable(en9), .filter_nine_mask_select(m9), .filter_nine_fifo_select(f9),
        .filter_eight_enable(en8), .filter_eight_mask_select(m8), .filter_eight_fifo_select(f8), .irq(irq));

    // Clock and a hang guard sized for the long prescale case
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Bench tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    // Read data is looked at only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    function automatic logic [31:0] err_word(input int t, input int r);
        logic tw;
        logic rw;
        tw = t >= 96 && t < 128;
        rw = r >= 96 && r < 128;
        return {10'h0, t >= 256, t >= 128, r >= 128, tw, rw, tw | rw, t >= 256 ? 8'hff : t[7:0], r[7:0]};
    endfunction
    // One bus outcome, mirrored in the expected counters
    task automatic hit(input int k);
        logic [31:0] w;
        @(posedge clk_sys);
        fire <= 1'b1;
        kind <= k[2:0];
        @(posedge clk_sys);
        fire <= 1'b0;
        case (k)
            0: tx = tx + 8 > 256 ? 256 : tx + 8;
            1: tx = tx > 0 && tx < 256 ? tx - 1 : tx;
            2: rx = rx < 255 ? rx + 1 : 255;
            3: rx = rx + 8 > 255 ? 255 : rx + 8;
            4: rx = rx >= 128 ? 119 : (rx > 0 ? rx - 1 : 0);
            default: begin
                tx = 0;
                rx = 0;
            end
        endcase
        w = err_word(tx, rx);
        rc(OFF_ERROR_COUNT_STATE, w);
        chk(32'({bo, txp, rxp, anyw}), 32'({w[21:19], w[16]}));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] w;
        logic [4:0] f;
        int p;
        int n;
        logic [15:0] c;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, an unmapped word and a write to a read-only word
        for (int a = 0; a <= 32; a += 4) rc(a[7:0], 32'h0);
        wr(OFF_ERROR_COUNT_STATE, 32'hffffffff);
        rc(OFF_ERROR_COUNT_STATE, 32'h0);
        repeat (120) hit($unsigned($random(seed)) % 5);
        // Walk to bus-off with interrupts armed, then mask and clear
        hit(5);
        wr(OFF_IRQ_CLEAR, 32'h3f);
        wr(OFF_IRQ_ENABLE, 32'h3f);
        repeat (33) hit(0);
        hit(1);
        rc(OFF_IRQ_STATUS, 32'h0b);
        chk(32'(irq), 32'h1);
        wr(OFF_IRQ_ENABLE, 32'h0);
        #1;
        chk(32'(irq), 32'h0);
        hit(5);
        wr(OFF_IRQ_CLEAR, 32'h3f);
        rc(OFF_IRQ_STATUS, 32'h0);
        // FIFO summaries, all-ones and all-zero first
        for (int i = 0; i < 4; i++) begin
            w = i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : $random(seed);
            @(posedge clk_sys);
            fifo_pend <= w;
            fifo_ovf <= ~w;
            rc(OFF_FIFO_INTERRUPT_PENDING, w);
            rc(OFF_RX_FIFO_OVERFLOW_PENDING, ~w);
        end
        // Timer steps for several prescales, a wrap and the longest period
        @(posedge clk_sys);
        cap <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            p = i == 5 ? 65535 : i == 4 ? 0 : (1 << i) - 1 + i / 2;
            c = i == 4 ? 16'hffff : 16'($random(seed));
            n = i == 5 ? 65535 : i == 4 ? 1 : 5 + $unsigned($random(seed)) % 30;
            wr(OFF_TIMESTAMP_TIMER, {c, p[15:0]});
            repeat (n) @(posedge clk_sys);
            #1;
            chk(32'(ts), 32'(16'(c + n / (p > 0 ? p : 1))));
        end
        // A second write restarts the prescale count
        wr(OFF_TIMESTAMP_TIMER, 32'h8);
        repeat (2) @(posedge clk_sys);
        wr(OFF_TIMESTAMP_TIMER, 32'h8);
        repeat (6) @(posedge clk_sys);
        #1;
        chk(32'(ts), 32'h0);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(32'(ts), 32'h1);
        // Frozen timer keeps count and prescale
        @(posedge clk_sys);
        cap <= 1'b0;
        wr(OFF_TIMESTAMP_TIMER, 32'h12340002);
        repeat (20) @(posedge clk_sys);
        rc(OFF_TIMESTAMP_TIMER, 32'h12340002);
        // Filters: every mask code, FIFO 0 and 31, lock while enabled
        for (int i = 0; i < 4; i++) begin
            f = i == 0 ? 5'h0 : 5'($random(seed));
            w = {16'h0, 1'b0, 2'(i), f, 1'b0, 2'(3 - i), ~f};
            wr(OFF_FILTER_CONTROL_TWO, w);
            rc(OFF_FILTER_CONTROL_TWO, w);
            wr(OFF_FILTER_CONTROL_TWO, w | 32'h8080);
            rc(OFF_FILTER_CONTROL_TWO, w | 32'h8080);
            chk(32'({en9, m9, f9, en8, m8, f8}), w | 32'h8080);
            wr(OFF_FILTER_CONTROL_TWO, {16'h0, ~w[15:0]} | 32'h8080);
            rc(OFF_FILTER_CONTROL_TWO, w | 32'h8080);
            wr(OFF_FILTER_CONTROL_TWO, 32'h0);
            rc(OFF_FILTER_CONTROL_TWO, w);
        end
        end_sim();
    end
endmodule

bind can_status_timer_filter_ctrl can_stf_props can_stf_props_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .fifo_irq_pending_in(fifo_irq_pending_in),
    .timestamp_capture_enable(timestamp_capture_enable), .any_warning_flag(any_warning_flag),
    .timestamp_count(timestamp_count), .filter_nine_enable(filter_nine_enable),
    .filter_nine_mask_select(filter_nine_mask_select), .filter_nine_fifo_select(filter_nine_fifo_select),
    .filter_eight_enable(filter_eight_enable), .filter_eight_mask_select(filter_eight_mask_select),
    .filter_eight_fifo_select(filter_eight_fifo_select));
